// ### rtl/epwm_top.sv
// Purpose: eight channel 8-bit pwm timer with an axi4-lite slave
// Assumes: aclk 10 MHz, synchronous active low aresetn
// Notes:   all outputs registered; one write and one read in flight
//
// Functional notes
// (RULE1) Eight independent pwm outputs come from one shared time base.
// (RULE2) With the clock enable bit at 0 the time base gets no clock.
// (RULE3) Enable 1 and clock choice 0 clocks the time base every cycle.
// (RULE4) Enable and choice 1 divide by 2,4,8,256,512,1024,4096.
// (RULE5) Divider pattern 011 divides the counter clock by 16.
// (RULE6) One resolution step lasts one selected counter clock period.
// (RULE7) A conversion period is exactly 256 resolution steps.
// (RULE8) Each conversion period holds 16 basic pulses.
// (RULE9) Duty runs from 0 in 1/256 steps; 100 percent needs port output.
// (RULE10) Bit 5 of the select register reads 1 and ignores writes.
// (RULE11) Bit 4 of the select register reads 0 and ignores writes.
// (RULE12) Pick values 0 to 7 route the data window to duty word 0 to 7.
// (RULE13) Pick values with bit 3 set leave duty words and outputs alone.
// (RULE14) Software clears the flash gate before reaching the divider.
// (RULE15) Duty upper nibble sets basic pulse width, lower adds pulses.
// (RULE16) A phase bit of 1 inverts the channel output.
// (RULE17) Direction and route bits pick port input, port or pwm output.
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "epwm_params.svh"
module epwm_top #(
  parameter int ADDR_W = 8,
  parameter int CH_N   = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              flash_register_gate,
  output logic [CH_N-1:0]        modulated_outputs,
  output logic [CH_N-1:0]        modulated_outputs_oe
);
  logic [7:0]        sel_q;
  logic [7:0]        duty_q [CH_N];
  logic [CH_N-1:0]   phase_q;
  logic [CH_N-1:0]   route_q;
  logic [CH_N-1:0]   dir_q;
  logic [CH_N-1:0]   pdata_q;
  logic [2:0]        div_q;
  logic [7:0]        count_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic              tick;
  logic [CH_N-1:0]   wave;
  logic [CH_N-1:0]   pin_d;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = a == ADDR_W'(off);
  endfunction : hit

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, `EPWM_OFF_SEL) || hit(a, `EPWM_OFF_DUTY) ||
             hit(a, `EPWM_OFF_PHASE) || hit(a, `EPWM_OFF_ROUTE) ||
             hit(a, `EPWM_OFF_DIV) || hit(a, `EPWM_OFF_DIR) ||
             hit(a, `EPWM_OFF_PDATA) || hit(a, `EPWM_OFF_COUNT);
  endfunction : mapped

  function automatic logic [3:0] rev4(input logic [3:0] v);
    rev4 = {v[0], v[1], v[2], v[3]};
  endfunction : rev4

  // write decode
  wire       do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  wire       wr_en    = do_write && wstrb_q[0];
  wire [7:0] wbyte    = wdata_q[7:0];
  wire       pick_off = sel_q[`EPWM_SEL_PICK];
  wire [2:0] pick_ch  = sel_q[2:0];
  wire       div_open = !flash_register_gate; // RULE14
  wire       wr_sel   = wr_en && hit(awaddr_q, `EPWM_OFF_SEL);
  wire       wr_duty  = wr_en && hit(awaddr_q, `EPWM_OFF_DUTY) &&
                        !pick_off; // RULE13
  wire       wr_phase = wr_en && hit(awaddr_q, `EPWM_OFF_PHASE);
  wire       wr_route = wr_en && hit(awaddr_q, `EPWM_OFF_ROUTE);
  wire       wr_div   = wr_en && hit(awaddr_q, `EPWM_OFF_DIV) &&
                        div_open; // RULE14
  wire       wr_dir   = wr_en && hit(awaddr_q, `EPWM_OFF_DIR);
  wire       wr_pdata = wr_en && hit(awaddr_q, `EPWM_OFF_PDATA);
  wire       wr_ok    = mapped(awaddr_q);

  // read decode; select bit 5 reads one, other reserved and unselected bits read zero
  wire [7:0] sel_rd   = (sel_q & `EPWM_SEL_WMASK) |
                        `EPWM_SEL_RST; // RULE10 RULE11
  wire [7:0] duty_rd  = pick_off ? `EPWM_BYTE_RST :
                        duty_q[pick_ch]; // RULE12
  wire [7:0] div_rd   = div_open ?
                        {4'h0, div_q, 1'b0} : `EPWM_BYTE_RST;
  wire [7:0] rd_byte  =
    hit(s_axi_araddr, `EPWM_OFF_SEL)   ? sel_rd  :
    hit(s_axi_araddr, `EPWM_OFF_DUTY)  ? duty_rd :
    hit(s_axi_araddr, `EPWM_OFF_PHASE) ? phase_q :
    hit(s_axi_araddr, `EPWM_OFF_ROUTE) ? route_q :
    hit(s_axi_araddr, `EPWM_OFF_DIV)   ? div_rd  :
    hit(s_axi_araddr, `EPWM_OFF_DIR)   ? dir_q   :
    hit(s_axi_araddr, `EPWM_OFF_PDATA) ? pdata_q :
    hit(s_axi_araddr, `EPWM_OFF_COUNT) ? count_q : `EPWM_BYTE_RST;

  // write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EPWM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `EPWM_RESP_OKAY : `EPWM_RESP_SLV;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end
    end
  end

  // read: answer on the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `EPWM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h0, rd_byte};
      s_axi_rresp   <= mapped(s_axi_araddr) ? `EPWM_RESP_OKAY :
                       `EPWM_RESP_SLV;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q   <= `EPWM_SEL_RST;
      phase_q <= '0;
      route_q <= '0;
      dir_q   <= '0;
      pdata_q <= '0;
      div_q   <= `EPWM_DIV_RST;
    end else begin
      if (wr_sel)   sel_q   <= wbyte & `EPWM_SEL_WMASK; // RULE10 RULE11
      if (wr_phase) phase_q <= wbyte[CH_N-1:0];
      if (wr_route) route_q <= wbyte[CH_N-1:0];
      if (wr_dir)   dir_q   <= wbyte[CH_N-1:0];
      if (wr_pdata) pdata_q <= wbyte[CH_N-1:0];
      if (wr_div)   div_q   <= wbyte[`EPWM_DIV_HI:`EPWM_DIV_LO];
    end
  end

  epwm_prescaler #(
    .PRE_W (12)
  ) u_pre (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .counter_clock_enable   (sel_q[`EPWM_SEL_EN]),
    .prescaled_clock_choice (sel_q[`EPWM_SEL_CHOICE]),
    .divider_bits           (div_q),
    .tick                   (tick)
  );

  // shared time base: low nibble is position, high nibble pulse number
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
    end else if (tick) begin
      count_q <= count_q + 8'h1; // RULE1 RULE6 RULE7
    end
  end

  wire [3:0] pos   = count_q[3:0]; // RULE8
  wire [3:0] pulse = count_q[7:4]; // RULE8

  generate
    for (genvar i = 0; i < CH_N; i++) begin : g_ch
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          duty_q[i] <= `EPWM_BYTE_RST;
        end else if (wr_duty && pick_ch == 3'(i)) begin
          duty_q[i] <= wbyte; // RULE12
        end
      end
      // extra pulse sits in the last step before a basic rising edge
      wire basic = pos < duty_q[i][7:4]; // RULE15
      wire extra = pos == `EPWM_POS_LAST &&
                   rev4(pulse) < duty_q[i][3:0]; // RULE15
      // with phase 0 at most 255 of 256 steps high, so full duty needs the port; phase 1 with duty 0 gives 256
      assign wave[i]  = (basic || extra) ^ phase_q[i]; // RULE9 RULE16
      assign pin_d[i] = !dir_q[i] ? 1'b0 :
                        route_q[i] ? wave[i] : pdata_q[i]; // RULE17
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modulated_outputs    <= '0;
      modulated_outputs_oe <= '0;
    end else begin
      modulated_outputs    <= pin_d; // RULE1
      modulated_outputs_oe <= dir_q; // RULE17
    end
  end

  property p_step;
    @(posedge aclk) disable iff (!aresetn)
      tick |=> count_q == $past(count_q) + 8'h1;
  endproperty
  a_step: assert property (p_step) // RULE6
    else $error("time base did not advance on tick");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
      !tick |=> $stable(count_q);
  endproperty
  a_hold: assert property (p_hold) // RULE2
    else $error("time base moved without a tick");

  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
      tick && count_q == `EPWM_COUNT_LAST |=> count_q == 8'h0;
  endproperty
  a_wrap: assert property (p_wrap) // RULE7
    else $error("time base did not wrap after 256 steps");

  property p_sel_bits;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, `EPWM_OFF_SEL)
      |=> s_axi_rdata[5:4] == 2'h2;
  endproperty
  a_sel_bits: assert property (p_sel_bits) // RULE10
    else $error("select register reserved bits wrong");

  property p_pick_off;
    @(posedge aclk) disable iff (!aresetn)
      do_write && pick_off |=> duty_q[0] == $past(duty_q[0]) &&
      duty_q[CH_N-1] == $past(duty_q[CH_N-1]);
  endproperty
  a_pick_off: assert property (p_pick_off) // RULE13
    else $error("duty word changed with pick bit 3 set");

  sequence s_ch0_zero;
    duty_q[0] == 8'h0 && !phase_q[0] && dir_q[0] && route_q[0];
  endsequence
  property p_zero;
    @(posedge aclk) disable iff (!aresetn)
      s_ch0_zero ##1 s_ch0_zero |-> !modulated_outputs[0];
  endproperty
  a_zero: assert property (p_zero) // RULE9
    else $error("zero duty produced a high output");

  property p_input;
    @(posedge aclk) disable iff (!aresetn)
      !dir_q[0] |=> !modulated_outputs_oe[0] && !modulated_outputs[0];
  endproperty
  a_input: assert property (p_input) // RULE17
    else $error("input pin was driven");

  property p_port;
    @(posedge aclk) disable iff (!aresetn)
      dir_q[1] && !route_q[1] |=> modulated_outputs[1] == $past(pdata_q[1]);
  endproperty
  a_port: assert property (p_port) // RULE17
    else $error("port output does not follow port data");

  property p_invert;
    @(posedge aclk) disable iff (!aresetn)
      dir_q[0] && route_q[0] && phase_q[0] && pos < duty_q[0][7:4]
      |=> !modulated_outputs[0];
  endproperty
  a_invert: assert property (p_invert) // RULE16
    else $error("inverted channel high inside the duty width");

  property p_extra;
    @(posedge aclk) disable iff (!aresetn)
      dir_q[0] && route_q[0] && !phase_q[0] && pos == `EPWM_POS_LAST &&
      pulse == 4'h0 && duty_q[0][3:0] != 4'h0 |=> modulated_outputs[0];
  endproperty
  a_extra: assert property (p_extra) // RULE15
    else $error("first added pulse missing");

  property p_duty_land;
    @(posedge aclk) disable iff (!aresetn)
      wr_duty && pick_ch == 3'h0 |=> duty_q[0] == $past(wbyte);
  endproperty
  a_duty_land: assert property (p_duty_land) // RULE12
    else $error("duty word 0 missed a write");

  property p_div_gate;
    @(posedge aclk) disable iff (!aresetn)
      flash_register_gate |=> $stable(div_q);
  endproperty
  a_div_gate: assert property (p_div_gate) // RULE14
    else $error("divider changed while gated");

  property p_div_hide;
    @(posedge aclk) disable iff (!aresetn)
      flash_register_gate && s_axi_arvalid && s_axi_arready &&
      hit(s_axi_araddr, `EPWM_OFF_DIV) |=> s_axi_rdata == 32'h0;
  endproperty
  a_div_hide: assert property (p_div_hide) // RULE14
    else $error("divider readable while gated");
endmodule : epwm_top

// ### rtl/epwm_params.svh
// Purpose: constants for the eight channel pwm timer
// Assumes: byte addresses on an axi4-lite bus, 32-bit data
// Notes:   definitions only
`ifndef EPWM_PARAMS_SVH
`define EPWM_PARAMS_SVH

// register byte offsets
`define EPWM_OFF_SEL    8'h00
`define EPWM_OFF_DUTY   8'h04
`define EPWM_OFF_PHASE  8'h08
`define EPWM_OFF_ROUTE  8'h0c
`define EPWM_OFF_DIV    8'h10
`define EPWM_OFF_DIR    8'h14
`define EPWM_OFF_PDATA  8'h18
`define EPWM_OFF_COUNT  8'h1c

// clock_and_channel_select fields
`define EPWM_SEL_EN     7
`define EPWM_SEL_CHOICE 6
`define EPWM_SEL_ONE    5
`define EPWM_SEL_ZERO   4
`define EPWM_SEL_PICK   3
`define EPWM_SEL_RST    8'h20
`define EPWM_SEL_WMASK  8'hcf

// peripheral_divider_select fields
`define EPWM_DIV_HI     3
`define EPWM_DIV_LO     1

// reset values
`define EPWM_BYTE_RST   8'h00
`define EPWM_DIV_RST    3'h0

// prescaler low-bit masks, tick when all masked bits are ones
`define EPWM_MASK_D2    12'h001
`define EPWM_MASK_D4    12'h003
`define EPWM_MASK_D8    12'h007
`define EPWM_MASK_D16   12'h00f
`define EPWM_MASK_D256  12'h0ff
`define EPWM_MASK_D512  12'h1ff
`define EPWM_MASK_D1K   12'h3ff
`define EPWM_MASK_D4K   12'hfff

// time base layout
`define EPWM_POS_LAST   4'hf
`define EPWM_COUNT_LAST 8'hff

// axi responses
`define EPWM_RESP_OKAY  2'h0
`define EPWM_RESP_SLV   2'h2

`endif

// ### rtl/epwm_pkg.sv
// Purpose: shared types of the eight channel pwm timer
// Assumes: nothing
// Notes:   gray coded clock source
package epwm_pkg;
  typedef enum logic [1:0] {
    EPWM_CLK_OFF    = 2'h0,
    EPWM_CLK_DIRECT = 2'h1,
    EPWM_CLK_DIV    = 2'h3
  } epwm_clk_e;
endpackage : epwm_pkg

// ### rtl/epwm_prescaler.sv
// Purpose: counter clock selection for the time base
// Assumes: one system clock, synchronous active low reset
// Notes:   tick is a one-cycle enable, not a derived clock
`timescale 1ns/100ps
`include "epwm_params.svh"
module epwm_prescaler #(
  parameter int PRE_W = 12
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       counter_clock_enable,
  input  wire logic       prescaled_clock_choice,
  input  wire logic [2:0] divider_bits,
  output logic            tick
);
  epwm_pkg::epwm_clk_e src;
  logic [PRE_W-1:0]    div_cnt_q;
  logic [PRE_W-1:0]    mask;

  function automatic logic [PRE_W-1:0] div_mask(input logic [2:0] d);
    case (d)
      3'h0:    div_mask = PRE_W'(`EPWM_MASK_D2);
      3'h1:    div_mask = PRE_W'(`EPWM_MASK_D4);
      3'h2:    div_mask = PRE_W'(`EPWM_MASK_D8);
      3'h3:    div_mask = PRE_W'(`EPWM_MASK_D16); // RULE5
      3'h4:    div_mask = PRE_W'(`EPWM_MASK_D256);
      3'h5:    div_mask = PRE_W'(`EPWM_MASK_D512);
      3'h6:    div_mask = PRE_W'(`EPWM_MASK_D1K);
      default: div_mask = PRE_W'(`EPWM_MASK_D4K);
    endcase
  endfunction : div_mask

  assign src  = !counter_clock_enable ? epwm_pkg::EPWM_CLK_OFF : // RULE2
                !prescaled_clock_choice ? epwm_pkg::EPWM_CLK_DIRECT :
                epwm_pkg::EPWM_CLK_DIV;
  assign mask = div_mask(divider_bits); // RULE4

  // counter restarts while stopped so the first tick is a full period
  always_ff @(posedge aclk) begin
    if (!aresetn || src == epwm_pkg::EPWM_CLK_OFF) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + PRE_W'(1);
    end
  end

  always_comb begin
    case (src)
      epwm_pkg::EPWM_CLK_OFF:    tick = 1'b0; // RULE2
      epwm_pkg::EPWM_CLK_DIRECT: tick = 1'b1; // RULE3
      epwm_pkg::EPWM_CLK_DIV:    tick = (div_cnt_q & mask) == mask; // RULE4
      default:                   tick = 1'b0;
    endcase
  end

  property p_off;
    @(posedge aclk) disable iff (!aresetn)
      !counter_clock_enable |-> !tick;
  endproperty
  a_off: assert property (p_off) // RULE2
    else $error("tick while clock disabled");

  property p_direct;
    @(posedge aclk) disable iff (!aresetn)
      counter_clock_enable && !prescaled_clock_choice |-> tick;
  endproperty
  a_direct: assert property (p_direct) // RULE3
    else $error("direct clock missed a tick");

  wire div2_run = counter_clock_enable && prescaled_clock_choice &&
                  divider_bits == 3'h0;
  sequence s_div2_run;
    div2_run;
  endsequence
  property p_div2;
    @(posedge aclk) disable iff (!aresetn)
      s_div2_run ##0 tick ##1 s_div2_run |-> !tick ##1 (!div2_run || tick);
  endproperty
  a_div2: assert property (p_div2) // RULE4
    else $error("divide by two pattern broken");

  property p_div16;
    @(posedge aclk) disable iff (!aresetn)
      tick && prescaled_clock_choice && divider_bits == 3'h3
      |-> div_cnt_q[3:0] == 4'hf;
  endproperty
  a_div16: assert property (p_div16) // RULE5
    else $error("divide by sixteen tick misplaced");
endmodule : epwm_prescaler

// ### verification/epwm_load_model.sv
// Purpose: load on the pwm pins, times or averages channel 0
// Assumes: pins sampled on aclk
// Notes:   win 0 times the second whole high run, else sums highs
`timescale 1ns/100ps
module epwm_load_model (
  input  wire logic        aclk,
  input  wire logic [7:0]  pins,
  input  wire logic [7:0]  oe,
  input  wire logic        start,
  input  wire logic [15:0] win,
  output logic             done = 1'b0,
  output logic [15:0]      result
);
  logic [15:0] cnt;
  logic [15:0] left;
  logic [15:0] run;
  logic        busy = 1'b0;
  logic        prev;
  logic [1:0]  falls;
  // an undriven pin reads low, the filter input is pulled down
  wire         lvl = oe[0] & pins[0];
  always @(posedge aclk) begin
    done <= 1'b0;
    prev <= lvl;
    run  <= lvl ? run + 16'h1 : 16'h0;
    if (start) begin
      busy  <= 1'b1;
      cnt   <= 16'h0;
      left  <= win;
      falls <= 2'h0;
    end else if (busy && win != 16'h0) begin
      cnt  <= cnt + 16'(lvl);
      left <= left - 16'h1;
      if (left == 16'h1) begin
        result <= cnt + 16'(lvl);
        done   <= 1'b1;
        busy   <= 1'b0;
      end
    end else if (busy && prev && !lvl) begin
      // first run may have begun before start, so take the second
      falls <= falls + 2'h1;
      if (falls == 2'h1) begin
        result <= run;
        done   <= 1'b1;
        busy   <= 1'b0;
      end
    end
  end
endmodule : epwm_load_model

// ### verification/test_eight_channel_pwm_timer.sv
// Purpose: self-checking bench of the pwm timer
// Assumes: aclk 10 MHz, reset held 5 cycles
// Notes:   expected values queued by drivers, compared by monitor
`timescale 1ns/100ps
`include "epwm_params.svh"
module test_eight_channel_pwm_timer;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        flash_register_gate;
  logic [7:0]  modulated_outputs;
  logic [7:0]  modulated_outputs_oe;
  logic        start;
  logic [15:0] win;
  logic        done;
  logic [15:0] result;
  logic [31:0] q_b[$];
  logic [31:0] q_r[$];
  logic [31:0] q_rr[$];
  logic [15:0] q_m[$];
  logic [7:0]  duty_v[8];
  logic [7:0]  pat[4];
  int          divs[8] = '{2, 4, 8, 16, 256, 512, 1024, 4096};
  int          n_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  int          seed_v;
  int          p;

  epwm_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .flash_register_gate(flash_register_gate),
    .modulated_outputs(modulated_outputs),
    .modulated_outputs_oe(modulated_outputs_oe)
  );

  epwm_load_model i_load (
    .aclk(aclk), .pins(modulated_outputs), .oe(modulated_outputs_oe),
    .start(start), .win(win), .done(done), .result(result)
  );

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic cmp_bus(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: bus exp %h got %h", $time, e, g);
    end
  endtask : cmp_bus

  task automatic cmp_meas(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: load exp %h got %h", $time, e, g);
    end
  endtask : cmp_meas

  // hang guard, whole run needs well under this
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      end_sim();
    end
  end

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready)
      cmp_bus(q_b.pop_front(), {30'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready) begin
      cmp_bus(q_r.pop_front(), s_axi_rdata);
      cmp_bus(q_rr.pop_front(), {30'h0, s_axi_rresp});
    end
    if (done)
      cmp_meas(q_m.pop_front(), result);
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] r = `EPWM_RESP_OKAY);
    logic aw_ok;
    logic w_ok;
    @(posedge aclk);
    q_b.push_back({30'h0, r});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready && !aw_ok) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = `EPWM_RESP_OKAY);
    @(posedge aclk);
    q_r.push_back(e);
    q_rr.push_back({30'h0, r});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic meas(input int w, input int e);
    @(posedge aclk);
    q_m.push_back(e[15:0]);
    win   <= w[15:0];
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    do @(posedge aclk); while (!done);
  endtask : meas

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  initial begin
    aresetn <= 1'b0;
    s_axi_awaddr <= 8'h00;
    s_axi_awvalid <= 1'b0;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_araddr <= 8'h00;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    flash_register_gate <= 1'b0;
    start <= 1'b0;
    win <= 16'h0;
    seed_v = $urandom(32'hdcda);
    do_reset();
    rd(`EPWM_OFF_SEL, 32'h20);
    rd(`EPWM_OFF_COUNT, 32'h0);
    rd(8'h20, 32'h0, `EPWM_RESP_SLV);
    wr(8'h24, 8'h5a, `EPWM_RESP_SLV);
    wr(`EPWM_OFF_SEL, 8'h1f);
    rd(`EPWM_OFF_SEL, 32'h2f);
    wr(`EPWM_OFF_SEL, 8'h00);
    rd(`EPWM_OFF_SEL, 32'h20);
    for (int n = 0; n < 8; n++) begin
      duty_v[n] = 8'($urandom);
      wr(`EPWM_OFF_SEL, 8'(n));
      wr(`EPWM_OFF_DUTY, duty_v[n]);
    end
    for (int n = 0; n < 8; n++) begin
      wr(`EPWM_OFF_SEL, 8'(n));
      rd(`EPWM_OFF_DUTY, {24'h0, duty_v[n]});
    end
    p = 8 + $urandom_range(7);
    wr(`EPWM_OFF_SEL, 8'(p));
    wr(`EPWM_OFF_DUTY, ~duty_v[0]);
    rd(`EPWM_OFF_DUTY, 32'h0);
    wr(`EPWM_OFF_SEL, 8'h00);
    rd(`EPWM_OFF_DUTY, {24'h0, duty_v[0]});
    // duties back to zero so the wave is known low
    do_reset();
    wr(`EPWM_OFF_DIR, 8'h0f);
    wr(`EPWM_OFF_ROUTE, 8'h05);
    wr(`EPWM_OFF_PDATA, 8'ha3);
    wr(`EPWM_OFF_PHASE, 8'hff);
    @(posedge aclk);
    cmp_bus(32'h07, {24'h0, modulated_outputs});
    cmp_bus(32'h0f, {24'h0, modulated_outputs_oe});
    wr(`EPWM_OFF_PHASE, 8'h00);
    @(posedge aclk);
    cmp_bus(32'h02, {24'h0, modulated_outputs});
    wr(`EPWM_OFF_DIR, 8'hff);
    wr(`EPWM_OFF_ROUTE, 8'hff);
    wr(`EPWM_OFF_DIV, 8'h0e);
    wr(`EPWM_OFF_DUTY, 8'h81);
    wr(`EPWM_OFF_SEL, 8'h80);
    meas(256, 129);
    wr(`EPWM_OFF_PHASE, 8'h01);
    meas(256, 127);
    wr(`EPWM_OFF_PHASE, 8'h00);
    pat = '{8'h00, 8'hff, 8'($urandom), 8'($urandom)};
    for (int n = 0; n < 4; n++) begin
      wr(`EPWM_OFF_DUTY, pat[n]);
      meas(256, int'(pat[n]));
    end
    wr(`EPWM_OFF_DUTY, 8'h80);
    meas(0, 8);
    flash_register_gate <= 1'b1;
    wr(`EPWM_OFF_DIV, 8'h02);
    rd(`EPWM_OFF_DIV, 32'h0);
    flash_register_gate <= 1'b0;
    rd(`EPWM_OFF_DIV, 32'h0e);
    for (int i = 0; i < 6; i++) begin
      wr(`EPWM_OFF_DIV, {4'h0, 3'(i), 1'b0});
      wr(`EPWM_OFF_SEL, 8'hc0);
      meas(0, 8 * divs[i]);
    end
    // slow dividers are too long to time, watch the count instead
    for (int i = 6; i < 8; i++) begin
      do_reset();
      wr(`EPWM_OFF_DIV, {4'h0, 3'(i), 1'b0});
      wr(`EPWM_OFF_SEL, 8'h40);
      repeat (50) @(posedge aclk);
      rd(`EPWM_OFF_COUNT, 32'h0);
      wr(`EPWM_OFF_SEL, 8'hc0);
      repeat (divs[i] * 3 / 2) @(posedge aclk);
      rd(`EPWM_OFF_COUNT, 32'h1);
    end
    repeat (3) @(posedge aclk);
    end_sim();
  end
endmodule : test_eight_channel_pwm_timer
